//--- hdl/mqfb_pkg.sv
// Purpose: Shared constants and types for the multi-queue flag boundary block
// Assumes: One clock for both ports; register offsets are byte addresses
// Notes:   Width mode encodings follow a Gray sequence

package mqfb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] REG_CTRL      = 8'h00; // Width mode
    localparam logic [7:0] REG_STATUS    = 8'h04; // Sticky events, write one to clear
    localparam logic [7:0] REG_MASK      = 8'h08; // Interrupt enables
    localparam logic [7:0] REG_QSEL      = 8'h0c; // Queue index for offset and fill access
    localparam logic [7:0] REG_AE_OFFSET = 8'h10; // Almost-empty offset of selected queue
    localparam logic [7:0] REG_FILL      = 8'h14; // Fill and flag view of selected queue

    ////////////////////////////////////////////////////////////////////////////
    // Default almost-empty offsets chosen by the strap
    localparam int AE_DEFAULT_LOW  = 8;   // Strap low at reset
    localparam int AE_DEFAULT_HIGH = 128; // Strap high at reset

    ////////////////////////////////////////////////////////////////////////////
    // Bus width pairings
    typedef enum logic [1:0] {
        MQFB_EQUAL     = 2'b00,           // Same width in and out
        MQFB_WIDE_IN   = 2'b01,           // Wide input, narrow output
        MQFB_NARROW_IN = 2'b11            // Narrow input, wide output
    } mqfb_width_type;

    localparam mqfb_width_type CTRL_RESET = MQFB_EQUAL;

    ////////////////////////////////////////////////////////////////////////////
    // Event bits of the status and mask registers
    typedef struct packed {
        logic rd_reject;                  // Read with no valid output word
        logic wr_reject;                  // Write into a full queue
        logic ae_entered;                 // Active read queue became almost empty
        logic full_entered;               // Active write queue became full
    } mqfb_evt_type;

    localparam int           EVT_BITS  = 4;
    localparam mqfb_evt_type EVT_RESET = 4'h0;

    // Active-low flag outputs travelling together
    typedef struct packed {
        logic full_n;                     // Write port full
        logic ae_n;                       // Read port almost empty
        logic ov_n;                       // Read port output valid
    } mqfb_flag_type;

    localparam mqfb_flag_type FLAG_RESET = 3'b101; // Not full, almost empty, no valid word

endpackage : mqfb_pkg

//--- hdl/mqfb_top.sv
// Purpose: Per-queue full, output-valid and almost-empty flag logic of a multi-queue FIFO
// Assumes: Write and read controllers share ref_clk; no data path is held here
// Notes:   Fill counts are in narrow-width units; one output word per queue may sit in the output stage
//
// Implementation choices: strobed register access and the placing of the registers.

`timescale 1ns/100ps
`default_nettype none

module mqfb_top #(
    parameter int NUM_QUEUES  = 8,                     // Number of queues
    parameter int QUEUE_DEPTH = 256,                   // Depth of each queue in words of the wider bus
    parameter int QAW         = $clog2(NUM_QUEUES)     // Queue address width
) (
    input  wire logic             ref_clk,                         // System clock
    input  wire logic             rst,                             // Synchronous reset, active high
    input  wire logic             default_offset_select,           // Strap for default offset
    input  wire logic [QAW-1:0]   write_queue_select_bus,          // Write queue address
    input  wire logic             write_select_strobe,             // Take write queue address
    input  wire logic             write_enable,                    // Write one input word
    input  wire logic [QAW-1:0]   read_queue_select_bus,           // Read queue address
    input  wire logic             read_select_strobe,              // Take read queue address
    input  wire logic             read_enable,                     // Read one output word
    output logic                  active_write_full_flag_n,        // Write queue full, active low
    output logic                  active_read_almost_empty_flag_n, // Read queue almost empty, active low
    output logic                  output_valid_flag_n,             // Output word valid, active low
    input  wire logic [7:0]       reg_addr,                        // Register byte address
    input  wire logic [31:0]      reg_wdata,                       // Register write data
    input  wire logic             reg_wr,                          // Register write strobe
    input  wire logic             reg_rd,                          // Register read strobe
    output logic      [31:0]      reg_rdata,                       // Read data, cycle after strobe
    output logic                  irq                              // Interrupt, active high level
);

    ////////////////////////////////////////////////////////////////////////////
    // Widths and limits
    localparam int CW = $clog2(2 * QUEUE_DEPTH + 1); // Fill count width
    localparam int SW = CW + 1;                      // Sum width with headroom

    localparam logic [SW-1:0] DEPTH_UNITS  = SW'(QUEUE_DEPTH);
    localparam logic [SW-1:0] DEPTH2_UNITS = SW'(2 * QUEUE_DEPTH);
    // Strap defaults larger than a short queue are clipped to its depth, never truncated
    localparam int            LOW_CLIP     = (mqfb_pkg::AE_DEFAULT_LOW > QUEUE_DEPTH) ?
                                             QUEUE_DEPTH : mqfb_pkg::AE_DEFAULT_LOW;
    localparam int            HIGH_CLIP    = (mqfb_pkg::AE_DEFAULT_HIGH > QUEUE_DEPTH) ?
                                             QUEUE_DEPTH : mqfb_pkg::AE_DEFAULT_HIGH;
    localparam logic [CW-1:0] OFF_LOW      = CW'(LOW_CLIP);
    localparam logic [CW-1:0] OFF_HIGH     = CW'(HIGH_CLIP);
    localparam logic [CW-1:0] OFF_MAX      = CW'(QUEUE_DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // State
    mqfb_pkg::mqfb_width_type mode_q;
    mqfb_pkg::mqfb_evt_type   status_q, status_d, mask_q, evt;
    mqfb_pkg::mqfb_flag_type  flags_q, flags_d;
    logic [QAW-1:0]           qsel_q;
    logic [QAW-1:0]           wr_sel1_q, wr_act_q, rd_sel1_q, rd_act_q;
    logic [CW-1:0]            cnt_q [NUM_QUEUES];
    logic [CW-1:0]            cnt_d [NUM_QUEUES];
    logic [CW-1:0]            off_q [NUM_QUEUES];
    logic [NUM_QUEUES-1:0]    ov_q, ov_d, nae, full_after;
    logic                     ae_stage_q;
    logic [31:0]              rdata_q, rdata_d;
    logic                     irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Unit weights of one input word, one output word and the queue capacity
    wire logic [SW-1:0] in_units  = (mode_q == mqfb_pkg::MQFB_WIDE_IN)   ? SW'(2) : SW'(1);
    wire logic [SW-1:0] out_units = (mode_q == mqfb_pkg::MQFB_NARROW_IN) ? SW'(2) : SW'(1);
    // Unused code 10 behaves as equal widths
    wire logic          two_unit  = (mode_q == mqfb_pkg::MQFB_WIDE_IN) || (mode_q == mqfb_pkg::MQFB_NARROW_IN);
    wire logic [SW-1:0] cap_units = two_unit ? DEPTH2_UNITS : DEPTH_UNITS;

    // Next queue selections, taken on the strobe edge
    wire logic [QAW-1:0] wr_sel1_d = write_select_strobe ? write_queue_select_bus : wr_sel1_q;
    wire logic [QAW-1:0] rd_sel1_d = read_select_strobe ? read_queue_select_bus : rd_sel1_q;

    // Accepted and refused port operations
    wire logic [SW-1:0] wr_room  = SW'(cnt_q[wr_act_q]) + in_units;
    wire logic          wr_full  = wr_room > cap_units;
    wire logic          wr_take  = write_enable && !wr_full;
    wire logic          rd_take  = read_enable && ov_q[rd_act_q];
    wire logic          wr_rej   = write_enable && wr_full;
    wire logic          rd_rej   = read_enable && !ov_q[rd_act_q];

    ////////////////////////////////////////////////////////////////////////////
    // Per-queue fill, fall-through and status compare
    always_comb begin
        logic [SW-1:0] inc;
        logic [SW-1:0] sum;
        logic [SW-1:0] thr;
        logic          ft;
        inc = '0;
        sum = '0;
        thr = '0;
        ft  = 1'b0;
        for (int q = 0; q < NUM_QUEUES; q++) begin
            // Only the active write queue gains units, on an accepted write
            inc = (wr_take && (wr_act_q == QAW'(q))) ? in_units : SW'(0);
            // Head word falls into the output stage of the read queue
            ft = (rd_act_q == QAW'(q)) && (!ov_q[q] || rd_take) && (SW'(cnt_q[q]) >= out_units);
            sum = SW'(cnt_q[q]) + inc - (ft ? out_units : SW'(0));
            cnt_d[q] = sum[CW-1:0];
            if (ft) begin
                ov_d[q] = 1'b1;
            end else if (rd_take && (rd_act_q == QAW'(q))) begin
                ov_d[q] = 1'b0;
            end else begin
                ov_d[q] = ov_q[q];
            end
            // Threshold in memory units, scaled by width pairing
            case (mode_q)
                mqfb_pkg::MQFB_WIDE_IN: begin
                    thr = {off_q[q], 1'b0};
                end
                mqfb_pkg::MQFB_NARROW_IN: begin
                    thr = {off_q[q], 1'b1};
                end
                default: begin
                    thr = SW'(off_q[q]);
                end
            endcase
            nae[q] = SW'(cnt_q[q]) > thr;
            full_after[q] = (SW'(cnt_q[q]) + inc + in_units) > cap_units;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output flags of the active queues
    always_comb begin
        flags_d.full_n = ~full_after[wr_act_q];
        flags_d.ae_n   = ae_stage_q;
        flags_d.ov_n   = ~ov_d[rd_act_q];
    end

    // Events that set sticky status bits
    always_comb begin
        evt.rd_reject    = rd_rej;
        evt.wr_reject    = wr_rej;
        evt.ae_entered   = flags_q.ae_n && !ae_stage_q;
        evt.full_entered = flags_q.full_n && !flags_d.full_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire logic hit_ctrl   = reg_addr == mqfb_pkg::REG_CTRL;
    wire logic hit_status = reg_addr == mqfb_pkg::REG_STATUS;
    wire logic hit_mask   = reg_addr == mqfb_pkg::REG_MASK;
    wire logic hit_qsel   = reg_addr == mqfb_pkg::REG_QSEL;
    wire logic hit_off    = reg_addr == mqfb_pkg::REG_AE_OFFSET;
    wire logic hit_fill   = reg_addr == mqfb_pkg::REG_FILL;

    localparam int EVT_W = mqfb_pkg::EVT_BITS;
    wire logic [EVT_W-1:0] clr_bits = (reg_wr && hit_status) ? reg_wdata[EVT_W-1:0] : '0;

    // Offset writes are clipped to the queue depth
    wire logic [CW-1:0] off_wr = (reg_wdata > 32'(QUEUE_DEPTH)) ? OFF_MAX : reg_wdata[CW-1:0];

    // Set wins over clear
    assign status_d = (status_q & ~clr_bits) | evt;

    // Read data mux, unmapped reads return zero
    always_comb begin
        rdata_d = 32'h0;
        if (!reg_rd) begin
            rdata_d = 32'h0;
        end else if (hit_ctrl) begin
            rdata_d = {30'h0, mode_q};
        end else if (hit_status) begin
            rdata_d = {28'h0, status_q};
        end else if (hit_mask) begin
            rdata_d = {28'h0, mask_q};
        end else if (hit_qsel) begin
            rdata_d = 32'(qsel_q);
        end else if (hit_off) begin
            rdata_d = 32'(off_q[qsel_q]);
        end else if (hit_fill) begin
            rdata_d = {13'h0, ov_q[qsel_q], nae[qsel_q], full_after[qsel_q], 16'(cnt_q[qsel_q])};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue selection pipelines, two edges from strobe to active
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_sel1_q <= '0;
            wr_act_q  <= '0;
            rd_sel1_q <= '0;
            rd_act_q  <= '0;
        end else begin
            wr_sel1_q <= wr_sel1_d;
            wr_act_q  <= wr_sel1_q;
            rd_sel1_q <= rd_sel1_d;
            rd_act_q  <= rd_sel1_q;
        end
    end

    // Per-queue fill counts and output-stage occupancy
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ov_q <= '0;
            for (int q = 0; q < NUM_QUEUES; q++) begin
                cnt_q[q] <= '0;
            end
        end else begin
            ov_q <= ov_d;
            for (int q = 0; q < NUM_QUEUES; q++) begin
                cnt_q[q] <= cnt_d[q];
            end
        end
    end

    // Per-queue offsets, strap default caught by the synchronous reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int q = 0; q < NUM_QUEUES; q++) begin
                off_q[q] <= default_offset_select ? OFF_HIGH : OFF_LOW;
            end
        end else if (reg_wr && hit_off) begin
            off_q[qsel_q] <= off_wr;
        end
    end

    // Flag stages; almost-empty passes two registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ae_stage_q <= 1'b0;
            flags_q    <= mqfb_pkg::FLAG_RESET;
        end else begin
            ae_stage_q <= nae[rd_sel1_q];
            flags_q    <= flags_d;
        end
    end

    // Software registers and interrupt
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_q   <= mqfb_pkg::CTRL_RESET;
            mask_q   <= mqfb_pkg::EVT_RESET;
            status_q <= mqfb_pkg::EVT_RESET;
            qsel_q   <= '0;
            rdata_q  <= 32'h0;
            irq_q    <= 1'b0;
        end else begin
            if (reg_wr && hit_ctrl) begin
                mode_q <= mqfb_pkg::mqfb_width_type'(reg_wdata[1:0]);
            end
            if (reg_wr && hit_mask) begin
                mask_q <= reg_wdata[EVT_W-1:0];
            end
            if (reg_wr && hit_qsel) begin
                qsel_q <= reg_wdata[QAW-1:0];
            end
            status_q <= status_d;
            rdata_q  <= rdata_d;
            irq_q    <= |(status_d & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign active_write_full_flag_n        = flags_q.full_n;
    assign active_read_almost_empty_flag_n = flags_q.ae_n;
    assign output_valid_flag_n             = flags_q.ov_n;
    assign reg_rdata                       = rdata_q;
    assign irq                             = irq_q;

endmodule : mqfb_top

`default_nettype wire

//--- verification/mqfb_ctl.sv
// Purpose: Behavioural write-side and read-side queue controller facing the flag block
// Assumes: Shares ref_clk with the flag block
// Notes:   Signals change by non-blocking assignment just after a rising edge

`timescale 1ns/100ps
`default_nettype none

module mqfb_ctl #(
    parameter int QAW = 3                 // Queue address width
) (
    input  wire logic           ref_clk,  // System clock
    output var  logic [QAW-1:0] wq_bus,   // Write queue address
    output var  logic           wq_stb,   // Write queue select strobe
    output var  logic           wr_en,    // Write one word
    output var  logic [QAW-1:0] rq_bus,   // Read queue address
    output var  logic           rq_stb,   // Read queue select strobe
    output var  logic           rd_en     // Read one word
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle controller at time zero
    initial begin
        wq_bus = '0;
        wq_stb = 1'b0;
        wr_en  = 1'b0;
        rq_bus = '0;
        rq_stb = 1'b0;
        rd_en  = 1'b0;
    end

    // Queue select: address beside a one-cycle strobe; address scrambled once released
    task automatic sel(input logic rd, input logic [QAW-1:0] q);
        @(posedge ref_clk);
        if (rd) begin
            rq_bus <= q;
            rq_stb <= 1'b1;
        end else begin
            wq_bus <= q;
            wq_stb <= 1'b1;
        end
        @(posedge ref_clk);
        rq_stb <= 1'b0;
        wq_stb <= 1'b0;
        rq_bus <= ~rq_bus;
        wq_bus <= ~wq_bus;
    endtask : sel

    // Back-to-back reads or writes, one per cycle; returns just after the last sampling edge
    task automatic pulse(input logic rd, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if (rd) rd_en <= 1'b1;
            else wr_en <= 1'b1;
        end
        @(posedge ref_clk);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask : pulse
endmodule : mqfb_ctl

`default_nettype wire

//--- verification/mqfb_top_chk.sv
// Purpose: Port-level timing checks of the flag block
// Assumes: One clock, synchronous active-high reset
// Notes:   Delays count from the edge that samples the cause

`timescale 1ns/100ps
`default_nettype none

module mqfb_top_chk (
    input wire logic        ref_clk,                         // Clock
    input wire logic        rst,                             // Reset
    input wire logic        write_select_strobe,             // Write select
    input wire logic        write_enable,                    // Write
    input wire logic        read_select_strobe,              // Read select
    input wire logic        read_enable,                     // Read
    input wire logic        active_write_full_flag_n,        // Full
    input wire logic        active_read_almost_empty_flag_n, // Almost empty
    input wire logic        output_valid_flag_n,             // Output valid
    input wire logic [7:0]  reg_addr,                        // Address
    input wire logic [31:0] reg_wdata,                       // Write data
    input wire logic        reg_wr,                          // Write strobe
    input wire logic        reg_rd,                          // Read strobe
    input wire logic [31:0] reg_rdata,                       // Read data
    input wire logic        irq                              // Interrupt
);
    ////////////////////////////////////////////////////////////////////////////////
    // All checks share one clock and reset
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Each flag change needs a cause at the exact distance
    full_fall_a: assert property ($fell(active_write_full_flag_n) |-> $past(write_enable) ||
        $past(write_select_strobe, 2) || $past(write_select_strobe, 3)) else $error("full without write");
    full_rise_a: assert property ($rose(active_write_full_flag_n) |-> $past(read_enable, 2) ||
        $past(write_select_strobe, 2) || $past(write_select_strobe, 3) || $past(rst)) else $error("full freed");
    ov_fall_a: assert property ($fell(output_valid_flag_n) |->
        $past(write_enable, 2) || $past(read_select_strobe, 3)) else $error("valid without write");
    ov_rise_a: assert property ($rose(output_valid_flag_n) |->
        $past(read_enable) || $past(read_select_strobe, 3) || $past(rst)) else $error("valid lost");
    ae_fall_a: assert property ($fell(active_read_almost_empty_flag_n) |->
        $past(read_enable, 3) || $past(read_select_strobe, 3) || $past(rst)) else $error("almost empty early");
    ae_rise_a: assert property ($rose(active_read_almost_empty_flag_n) |->
        $past(write_enable, 3) || $past(read_select_strobe, 3)) else $error("almost empty cleared");
    reset_vals_a: assert property ($past(rst) |-> active_write_full_flag_n && !active_read_almost_empty_flag_n
        && output_valid_flag_n && !irq && reg_rdata == 32'h0) else $error("reset values wrong");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
    irq_masked_a: assert property (reg_wr && reg_addr == mqfb_pkg::REG_MASK && reg_wdata[3:0] == 4'h0
        |-> ##2 !irq) else $error("masked interrupt high");
endmodule : mqfb_top_chk

bind mqfb_top mqfb_top_chk u_chk (.ref_clk(ref_clk), .rst(rst), .write_select_strobe(write_select_strobe),
    .write_enable(write_enable), .read_select_strobe(read_select_strobe), .read_enable(read_enable),
    .active_write_full_flag_n(active_write_full_flag_n), .output_valid_flag_n(output_valid_flag_n),
    .active_read_almost_empty_flag_n(active_read_almost_empty_flag_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

`default_nettype wire

//--- verification/tb_top.sv
// Purpose: Self-checking bench of the multi-queue flag block
// Assumes: Depth 16 queues, strap low unless stated
// Notes:   Flags are sampled 1 ns after the edge that updates them

`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam int DEPTH = 16; // Short queues keep fills brief
    localparam int OFS   = mqfb_pkg::AE_DEFAULT_LOW;
    logic ref_clk, rst, strap, ws, we, rs, re, full_n, ae_n, ov_n, reg_wr, reg_rd, irq;
    logic [2:0] wq, rq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    int mismatches, n_compared, ko, ka, kf;
    int kf_sh [3] = '{DEPTH + 1, DEPTH, 2 * (DEPTH + 1)};
    int kf_al [3] = '{DEPTH, DEPTH, 2 * DEPTH};
    int ko_x [3] = '{1, 1, 2};
    int ka_x [3] = '{OFS + 2, OFS + 1, 2 * (OFS + 2)};
    mqfb_pkg::mqfb_width_type md [3] = '{mqfb_pkg::MQFB_EQUAL, mqfb_pkg::MQFB_WIDE_IN, mqfb_pkg::MQFB_NARROW_IN};

    mqfb_ctl #(.QAW(3)) ctl (.ref_clk(ref_clk), .wq_bus(wq), .wq_stb(ws), .wr_en(we), .rq_bus(rq),
        .rq_stb(rs), .rd_en(re));
    mqfb_top #(.NUM_QUEUES(8), .QUEUE_DEPTH(DEPTH)) dut (.ref_clk(ref_clk), .rst(rst),
        .default_offset_select(strap), .write_queue_select_bus(wq), .write_select_strobe(ws),
        .write_enable(we), .read_queue_select_bus(rq), .read_select_strobe(rs), .read_enable(re),
        .active_write_full_flag_n(full_n), .active_read_almost_empty_flag_n(ae_n),
        .output_valid_flag_n(ov_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 20 ns period
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    task automatic do_reset(input logic s);
        @(posedge ref_clk);
        rst <= 1'b1;
        strap <= s;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask : do_reset

    task automatic tick_chk(input logic seen_sel, input logic [31:0] exp);
        @(posedge ref_clk);
        #1 chk(seen_sel ? ae_n : ov_n, exp);
    endtask : tick_chk

    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {rst, strap, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b10, 2'b00, 8'h00, 32'h0};
        do_reset(1'b0);
        reg_read(mqfb_pkg::REG_CTRL, rv);
        chk(rv, 32'h0);
        reg_read(mqfb_pkg::REG_AE_OFFSET, rv);
        chk(rv, OFS);
        reg_write(mqfb_pkg::REG_QSEL, 32'h3);
        reg_write(mqfb_pkg::REG_AE_OFFSET, 32'h5);
        reg_read(mqfb_pkg::REG_AE_OFFSET, rv);
        chk(rv, 32'h5);
        reg_write(mqfb_pkg::REG_AE_OFFSET, DEPTH + 1);
        reg_read(mqfb_pkg::REG_AE_OFFSET, rv);
        chk(rv, DEPTH);
        reg_read(8'h18, rv);
        chk(rv, 32'h0);
        reg_write(mqfb_pkg::REG_QSEL, 32'h0);
        // Both ports on queue 0: fill, refuse, drain
        ctl.pulse(1'b0, 1);
        #1 chk(ov_n, 1'b1);
        tick_chk(1'b0, 1'b0);
        ctl.pulse(1'b0, OFS);
        repeat (2) @(posedge ref_clk);
        #1 chk(ae_n, 1'b0);
        ctl.pulse(1'b0, 1);
        tick_chk(1'b1, 1'b0);
        tick_chk(1'b1, 1'b1);
        ctl.pulse(1'b0, DEPTH - OFS - 2);
        #1 chk(full_n, 1'b1);
        ctl.pulse(1'b0, 2);
        #1 chk(full_n, 1'b0);
        reg_read(mqfb_pkg::REG_STATUS, rv);
        chk(rv & 32'h5, 32'h5);
        ctl.pulse(1'b1, 1);
        #1 chk(full_n, 1'b0);
        @(posedge ref_clk);
        #1 chk(full_n, 1'b1);
        ctl.pulse(1'b1, 6);
        repeat (2) @(posedge ref_clk);
        #1 chk(ae_n, 1'b1);
        ctl.pulse(1'b1, 1);
        tick_chk(1'b1, 1'b1);
        tick_chk(1'b1, 1'b0);
        ctl.pulse(1'b1, OFS);
        #1 chk(ov_n, 1'b0);
        ctl.pulse(1'b1, 1);
        #1 chk(ov_n, 1'b1);
        // Interrupt raised, cleared and masked
        chk(irq, 1'b0);
        reg_write(mqfb_pkg::REG_MASK, 32'hf);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1'b1);
        reg_write(mqfb_pkg::REG_STATUS, 32'hf);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1'b0);
        reg_read(mqfb_pkg::REG_STATUS, rv);
        chk(rv, 32'h0);
        reg_write(mqfb_pkg::REG_MASK, 32'h0);
        // Fill queue 2 unread, then switch the read port onto it
        ctl.sel(1'b0, 3'h2);
        repeat (2) @(posedge ref_clk);
        ctl.pulse(1'b0, DEPTH - 1);
        #1 chk(full_n, 1'b1);
        ctl.pulse(1'b0, 1);
        #1 chk(full_n, 1'b0);
        ctl.sel(1'b0, 3'h0);
        repeat (3) @(posedge ref_clk);
        ctl.sel(1'b1, 3'h2);
        tick_chk(1'b1, 1'b0);
        tick_chk(1'b1, 1'b1);
        #0 chk(ov_n, 1'b0);
        // Full-flag boundary for every width pairing, shared and alone; valid and almost-empty boundaries only when shared
        for (int m = 0; m < 3; m++) begin
            for (int sh = 0; sh < 2; sh++) begin
                do_reset(1'b0);
                reg_write(mqfb_pkg::REG_CTRL, {30'h0, md[m]});
                if (sh == 0) ctl.sel(1'b1, 3'h1);
                {ko, ka, kf} = '0;
                for (int k = 1; k <= 40 && kf == 0; k++) begin
                    ctl.pulse(1'b0, 1);
                    repeat (2) @(posedge ref_clk);
                    #1 if (ko == 0 && ov_n === 1'b0) ko = k;
                    if (ka == 0 && ae_n === 1'b1) ka = k;
                    if (full_n === 1'b0) kf = k;
                end
                chk(kf, sh ? kf_sh[m] : kf_al[m]);
                if (sh) chk(ko, ko_x[m]);
                if (sh) chk(ka, ka_x[m]);
            end
        end
        do_reset(1'b1);
        reg_read(mqfb_pkg::REG_AE_OFFSET, rv);
        chk(rv, (mqfb_pkg::AE_DEFAULT_HIGH > DEPTH) ? DEPTH : mqfb_pkg::AE_DEFAULT_HIGH);
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
